// ==== design/stt_cnt_if.sv ====
`timescale 1ns/1ps
interface stt_cnt_if;
	logic        tick;
	logic        load;
	logic        clear;
	logic [23:0] reload_val;
	logic [23:0] count;
	logic        wrap;

	modport ctrl (output tick, output load, output clear, output reload_val,
		input count, input wrap);
	modport core (input tick, input load, input clear, input reload_val,
		output count, output wrap);
endinterface

// ==== design/stt_counter.sv ====
`timescale 1ns/1ps
module stt_counter (
	input wire logic clk_sys,
	stt_cnt_if.core  cif
);
	// ==========================================================
	// Counter core
	logic [23:0] count_reg;
	logic [23:0] count_next;
	logic        at_zero;

	assign at_zero = (count_reg == stt_pkg::STT_CNT_ZERO);
	assign count_next = cif.clear ? stt_pkg::STT_CNT_ZERO :                  // RULE11
		cif.load ? cif.reload_val :                                       // RULE6
		!cif.tick ? count_reg :                                           // RULE2 RULE20
		at_zero ? cif.reload_val :                                        // RULE1 RULE7
		count_reg - stt_pkg::STT_CNT_ONE;                                 // RULE1

	// Left without reset on purpose: value is unknown until software writes it
	always_ff @(posedge clk_sys) begin
		count_reg <= count_next; // RULE17
	end

	// Only a one-to-zero step counts as a wrap
	assign cif.wrap  = cif.tick & ~cif.load & ~cif.clear
		& (count_reg == stt_pkg::STT_CNT_ONE); // RULE9
	assign cif.count = count_reg;
endmodule // stt_counter

// ==== design/stt_pkg.sv ====
package stt_pkg;

	// ==========================================================
	// Widths
	localparam int STT_ADDR_W = 32;
	localparam int STT_DATA_W = 32;
	localparam int STT_CNT_W  = 24;

	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] STT_ADDR_CTRL    = 32'he000e010;
	localparam logic [31:0] STT_ADDR_RELOAD  = 32'he000e014;
	localparam logic [31:0] STT_ADDR_CURRENT = 32'he000e018;
	localparam logic [31:0] STT_ADDR_CALIB   = 32'he000e01c;

	// ==========================================================
	// Field positions
	localparam int STT_BIT_ENABLE     = 0;
	localparam int STT_BIT_IRQ_EN     = 1;
	localparam int STT_BIT_CLK_SEL    = 2;
	localparam int STT_BIT_FLAG       = 16;
	localparam int STT_BIT_REF_ABSENT = 31;
	localparam int STT_BIT_SKEW       = 30;
	localparam int STT_CAL_RSV_W      = 6;

	// ==========================================================
	// Reset values
	localparam logic [31:0] STT_CTRL_RESET        = 32'h0000_0000;
	localparam logic [31:0] STT_CTRL_RESET_NO_REF = 32'h0000_0004;
	localparam logic [31:0] STT_RDATA_NONE        = 32'h0000_0000;

	// ==========================================================
	// Timing
	localparam int STT_CLK_PERIOD_NS = 100;
	localparam int STT_TEN_MS_NS     = 10_000_000;
	localparam int STT_TEN_MS_CYCLES = STT_TEN_MS_NS / STT_CLK_PERIOD_NS;
	localparam logic [23:0] STT_TEN_MS_DEFAULT = 24'(STT_TEN_MS_CYCLES - 1);
	localparam logic [23:0] STT_CNT_ZERO = 24'h00_0000;
	localparam logic [23:0] STT_CNT_ONE  = 24'h00_0001;

endpackage

// ==== design/stt_ref_sync.sv ====
`timescale 1ns/1ps
module stt_ref_sync (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic ref_clk_pin,
	output logic      ref_edge
);
	// ==========================================================
	// Two-flop synchroniser, then rising edge detect
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= ref_clk_pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// Reference must run below half of clk_sys or edges are lost
	assign ref_edge = sync_reg & ~last_reg; // RULE21
endmodule // stt_ref_sync

// ==== design/stt_timer.sv ====
`timescale 1ns/1ps
// Function
// RULE1: 24-bit down counter; reloads on the edge after zero, then keeps counting.
// RULE2: Counter holds its value while the debugger halts the processor.
// RULE3: Bit 16 of control/status flags a zero since last read; the read clears it.
// RULE4: Control bit 2 picks the clock: 0 reference clock, 1 processor clock.
// RULE5: Exception request on count to zero only when control bit 1 is set.
// RULE6: Setting enable loads the reload value, then counts; clearing it stops.
// RULE7: At zero: set flag, request if enabled, reload and continue.
// RULE8: Reload register holds 24 bits; bits 31 to 24 read zero.
// RULE9: Reload of zero is legal but never yields flag or request.
// RULE10: Software programs N minus one for a period of N counting clocks.
// RULE11: Current value reads the live count; any write zeroes it and the flag.
// RULE12: Calibration bit 31 shows reference absent; then clock select reads one.
// RULE13: Control resets to zero, or to clock select only when no reference.
// RULE14: Calibration bit 30 shows the ten-millisecond count inexact or absent.
// RULE15: Calibration bits 23 to 0 give the 10 ms reload, zero meaning unknown.
// RULE16: Calibration register is read-only and fixed by the implementation.
// RULE17: Reload and current values are not initialised by reset.
// RULE18: Software writes reload, then clears current, then programs control.
// RULE19: Software uses aligned 32-bit word accesses only.
// RULE20: Counter stops while processor clocks are gated in deep sleep.
// RULE21: Reference clock edges are synchronised and each one decrements once.
module stt_timer #(
	parameter bit          REF_PRESENT = 1'b1,
	parameter bit          CAL_SKEW    = 1'b0,
	parameter logic [23:0] CAL_TEN_MS  = stt_pkg::STT_TEN_MS_DEFAULT
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rd_data,
	input  wire logic        dbg_halt,
	input  wire logic        deep_sleep,
	input  wire logic        ref_clk_pin,
	output logic             tick_irq
);

	// ==========================================================
	// Declarations
	stt_cnt_if cif ();

	logic        enable_reg;
	logic        irq_en_reg;
	logic        clk_sel_reg;
	logic        flag_reg;
	logic        flag_next;
	logic [23:0] reload_reg;
	logic [31:0] rd_data_reg;
	logic [31:0] rd_data_next;
	logic        tick_irq_reg;
	logic        ref_edge;
	logic        cnt_valid_reg;

	localparam logic CLK_SEL_RST = REF_PRESENT
		? stt_pkg::STT_CTRL_RESET[stt_pkg::STT_BIT_CLK_SEL]
		: stt_pkg::STT_CTRL_RESET_NO_REF[stt_pkg::STT_BIT_CLK_SEL];
	localparam logic ENABLE_RST = stt_pkg::STT_CTRL_RESET[stt_pkg::STT_BIT_ENABLE];
	localparam logic IRQ_EN_RST = stt_pkg::STT_CTRL_RESET[stt_pkg::STT_BIT_IRQ_EN];
	localparam logic FLAG_RST   = stt_pkg::STT_CTRL_RESET[stt_pkg::STT_BIT_FLAG];

	// ==========================================================
	// Address decode
	wire sel_ctrl    = (addr == stt_pkg::STT_ADDR_CTRL);
	wire sel_reload  = (addr == stt_pkg::STT_ADDR_RELOAD);
	wire sel_current = (addr == stt_pkg::STT_ADDR_CURRENT);
	wire sel_calib   = (addr == stt_pkg::STT_ADDR_CALIB);

	wire wr_ctrl    = wr_en & sel_ctrl;
	wire wr_reload  = wr_en & sel_reload;
	wire wr_current = wr_en & sel_current;
	wire rd_ctrl    = rd_en & sel_ctrl;

	wire enable_wr  = wr_data[stt_pkg::STT_BIT_ENABLE];
	wire irq_en_wr  = wr_data[stt_pkg::STT_BIT_IRQ_EN];
	// Without a reference the selector is stuck at processor clock
	wire clk_sel_wr = REF_PRESENT ? wr_data[stt_pkg::STT_BIT_CLK_SEL] : 1'b1; // RULE12

	// ==========================================================
	// Read words
	wire [31:0] ctrl_word = {15'h0000, flag_reg, 13'h0000,
		clk_sel_reg, irq_en_reg, enable_reg}; // RULE3 RULE4 RULE5
	wire [31:0] reload_word  = {8'h00, reload_reg}; // RULE8
	wire [31:0] current_word = {8'h00, cif.count}; // RULE11
	// Calibration is built from parameters only, no write path exists
	wire [31:0] calib_word = {~REF_PRESENT, CAL_SKEW,
		{stt_pkg::STT_CAL_RSV_W{1'b0}}, CAL_TEN_MS}; // RULE12 RULE14 RULE15 RULE16

	assign rd_data_next = !rd_en ? stt_pkg::STT_RDATA_NONE :
		sel_ctrl    ? ctrl_word :
		sel_reload  ? reload_word :
		sel_current ? current_word :
		sel_calib   ? calib_word :
		stt_pkg::STT_RDATA_NONE;

	// ==========================================================
	// Counter control
	stt_ref_sync u_ref_sync (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.ref_clk_pin (ref_clk_pin),
		.ref_edge    (ref_edge)
	);

	// Gated clocks in deep sleep and debug halt both freeze the count
	assign cif.tick = enable_reg & ~dbg_halt & ~deep_sleep
		& (clk_sel_reg | ref_edge); // RULE2 RULE4 RULE20 RULE21
	assign cif.load       = wr_ctrl & enable_wr & ~enable_reg; // RULE6
	assign cif.clear      = wr_current; // RULE11
	assign cif.reload_val = reload_reg;

	stt_counter u_counter (
		.clk_sys (clk_sys),
		.cif     (cif)
	);

	// Wrap beats a clearing read in the same cycle
	assign flag_next = cif.wrap ? 1'b1 :
		(rd_ctrl | wr_current) ? 1'b0 : flag_reg; // RULE3 RULE7 RULE11

	// ==========================================================
	// Control and status flops
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg  <= ENABLE_RST; // RULE13
			irq_en_reg  <= IRQ_EN_RST;
			clk_sel_reg <= CLK_SEL_RST; // RULE13
			flag_reg    <= FLAG_RST;
		end else begin
			if (wr_ctrl) begin
				enable_reg  <= enable_wr; // RULE6
				irq_en_reg  <= irq_en_wr;
				clk_sel_reg <= clk_sel_wr;
			end
			flag_reg <= flag_next;
		end
	end

	// Reload is kept unreset; software must write it before enabling
	always_ff @(posedge clk_sys) begin
		if (wr_reload) begin
			reload_reg <= wr_data[23:0]; // RULE8 RULE17
		end
	end

	// Count is unknown until the first clear, so the stopped check waits for it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_valid_reg <= 1'b0;
		end else if (cif.clear) begin
			cnt_valid_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_reg  <= stt_pkg::STT_RDATA_NONE;
			tick_irq_reg <= 1'b0;
		end else begin
			rd_data_reg  <= rd_data_next;
			tick_irq_reg <= cif.wrap & irq_en_reg; // RULE5 RULE7
		end
	end

	assign rd_data  = rd_data_reg;
	assign tick_irq = tick_irq_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_DECREMENT: assert property ( // RULE1
		cif.tick && !cif.load && !cif.clear && cif.count != stt_pkg::STT_CNT_ZERO
		|=> cif.count == $past(cif.count) - stt_pkg::STT_CNT_ONE)
		else $error("count did not decrement by one");

	AST_RELOAD_AT_ZERO: assert property ( // RULE1
		cif.tick && !cif.load && !cif.clear && cif.count == stt_pkg::STT_CNT_ZERO
		|=> cif.count == $past(reload_reg))
		else $error("count did not reload after zero");

	AST_HALT_HOLD: assert property ( // RULE2
		dbg_halt && !cif.load && !cif.clear |=> $stable(cif.count))
		else $error("count moved while halted");

	AST_FLAG_SET: assert property ( // RULE3
		cif.wrap |=> flag_reg)
		else $error("zero flag not set on wrap");

	AST_FLAG_READ_CLEAR: assert property ( // RULE3
		rd_ctrl && flag_reg && !cif.wrap
		|=> rd_data[stt_pkg::STT_BIT_FLAG] && !flag_reg)
		else $error("flag read did not return one and clear");

	AST_REF_TICK: assert property ( // RULE4
		cif.tick && !clk_sel_reg |-> ref_edge)
		else $error("reference mode ticked without reference edge");

	AST_IRQ_CAUSE: assert property ( // RULE5
		tick_irq |-> $past(cif.wrap) && $past(irq_en_reg))
		else $error("request without enabled wrap");

	AST_IRQ_ON_WRAP: assert property ( // RULE7
		cif.wrap && irq_en_reg |=> tick_irq ##1 !tick_irq)
		else $error("request missing or longer than one cycle");

	AST_ENABLE_LOAD: assert property ( // RULE6
		cif.load |=> cif.count == $past(reload_reg))
		else $error("enable did not load reload value");

	AST_STOPPED: assert property ( // RULE6
		cnt_valid_reg && !enable_reg && !cif.load && !cif.clear |=> $stable(cif.count))
		else $error("count moved while disabled");

	AST_RELOAD_RSV: assert property ( // RULE8
		$past(rd_en) && $past(sel_reload) |-> rd_data[31:24] == 8'h00)
		else $error("reload reserved bits nonzero");

	AST_CUR_CLEAR: assert property ( // RULE11
		wr_current |=> cif.count == stt_pkg::STT_CNT_ZERO && !flag_reg)
		else $error("current write did not clear count and flag");

	AST_REFERENCE_ABSENT_SEL: assert property ( // RULE12
		!REF_PRESENT |-> clk_sel_reg)
		else $error("selector not one without reference");

	AST_CALIB_READ: assert property ( // RULE16
		rd_en && sel_calib |=> rd_data == calib_word)
		else $error("calibration read mismatch");

	AST_SLEEP_HOLD: assert property ( // RULE20
		deep_sleep && !cif.load && !cif.clear |=> $stable(cif.count))
		else $error("count moved in deep sleep");

	AST_IRQ_MASKED: assert property ( // RULE5
		!irq_en_reg |=> !tick_irq)
		else $error("request raised while masked");

	AST_FLAG_STICKY: assert property ( // RULE3
		flag_reg && !rd_ctrl && !wr_current |=> flag_reg)
		else $error("zero flag dropped without clear");

	AST_FLAG_NO_SPURIOUS: assert property ( // RULE9
		!flag_reg && !cif.wrap |=> !flag_reg)
		else $error("zero flag set without a one-to-zero step");

	AST_CUR_READ: assert property ( // RULE11
		rd_en && sel_current |=> rd_data == {8'h00, $past(cif.count)})
		else $error("current read did not return live count");

	AST_CTRL_READ: assert property ( // RULE4
		rd_ctrl |=> rd_data[stt_pkg::STT_BIT_CLK_SEL] == $past(clk_sel_reg))
		else $error("clock select read mismatch");

	AST_REF_EDGE_PULSE: assert property ( // RULE21
		ref_edge |=> !ref_edge)
		else $error("reference edge longer than one cycle");

	AST_LOAD_WHEN_OFF: assert property ( // RULE6
		cif.load |-> !enable_reg && enable_wr)
		else $error("load without enable rising");

	COV_WRAP_IRQ: cover property (cif.wrap && irq_en_reg ##1 tick_irq);
	COV_FLAG_READ: cover property (flag_reg && rd_ctrl ##1 rd_data[stt_pkg::STT_BIT_FLAG]);
	COV_REF_TICK: cover property (cif.tick && !clk_sel_reg);
	COV_HALT_WRAP: cover property (dbg_halt && enable_reg ##1 !dbg_halt ##[1:20] cif.wrap);

endmodule // stt_timer

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Signals
	localparam logic [23:0] TB_TEN_MS = 24'h00_1234;
	logic        clk_sys;
	logic        arst_n;
	logic [31:0] addr;
	logic [31:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rd_data;
	logic        dbg_halt;
	logic        deep_sleep;
	logic        ref_clk_pin;
	logic        tick_irq;
	int          n_errors;
	int          comparisons;
	int          n_irq = 0;
	integer      seed;
	logic [31:0] d;
	logic [31:0] a0;
	int          c;
	int          r;
	int          n0;

	stt_timer #(.REF_PRESENT(1'b1), .CAL_SKEW(1'b1), .CAL_TEN_MS(TB_TEN_MS)) stt_timer_i (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.addr        (addr),
		.wr_data     (wr_data),
		.wr_en       (wr_en),
		.rd_en       (rd_en),
		.rd_data     (rd_data),
		.dbg_halt    (dbg_halt),
		.deep_sleep  (deep_sleep),
		.ref_clk_pin (ref_clk_pin),
		.tick_irq    (tick_irq)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (tick_irq === 1'b1) n_irq <= n_irq + 1;
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= v;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(v, exp);
	endtask

	// Software order: reload, clear current, then control
	task automatic start(input logic [31:0] rel, input logic [31:0] ctl);
		wr(stt_pkg::STT_ADDR_RELOAD, rel);
		wr(stt_pkg::STT_ADDR_CURRENT, 32'h0000_0000);
		wr(stt_pkg::STT_ADDR_CTRL, ctl);
	endtask

	task automatic wait_irq(output int cyc);
		cyc = -1;
		for (int i = 1; i <= 1000; i++) begin
			@(posedge clk_sys);
			#1;
			if (tick_irq === 1'b1) begin
				cyc = i;
				break;
			end
		end
		if (cyc < 0) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
			final_report();
		end
	endtask

	// Slow reference: high and low for three system clocks each
	task automatic ref_pulses(input int n);
		repeat (n) begin
			repeat (3) @(posedge clk_sys);
			ref_clk_pin <= 1'b1;
			repeat (3) @(posedge clk_sys);
			ref_clk_pin <= 1'b0;
		end
		repeat (6) @(posedge clk_sys);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		seed = 67;
		arst_n = 1'b0;
		addr = 32'h0000_0000;
		wr_data = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		dbg_halt = 1'b0;
		deep_sleep = 1'b0;
		ref_clk_pin = 1'b0;
		n_errors = 0;
		comparisons = 0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;

		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0000_0000);
		rdchk(stt_pkg::STT_ADDR_CALIB, {2'b01, 6'h00, TB_TEN_MS});
		wr(stt_pkg::STT_ADDR_CALIB, 32'hffff_ffff);
		rdchk(stt_pkg::STT_ADDR_CALIB, {2'b01, 6'h00, TB_TEN_MS});
		rdchk(32'he000e020, 32'h0000_0000);
		wr(stt_pkg::STT_ADDR_RELOAD, 32'hffab_cdef);
		rdchk(stt_pkg::STT_ADDR_RELOAD, 32'h00ab_cdef);
		$display("test reset_and_map done");

		r = 20 + ($unsigned($random(seed)) % 8);
		start(32'(r), 32'h0000_0003);
		rdchk(stt_pkg::STT_ADDR_CURRENT, 32'(r));
		ref_pulses(5);
		rdchk(stt_pkg::STT_ADDR_CURRENT, 32'(r - 5));
		wr(stt_pkg::STT_ADDR_CTRL, 32'h0000_0000);
		ref_pulses(3);
		rdchk(stt_pkg::STT_ADDR_CURRENT, 32'(r - 5));
		$display("test reference_clock done");

		r = 1 + ($unsigned($random(seed)) % 16);
		start(32'(r), 32'h0000_0007);
		wait_irq(c);
		wait_irq(c);
		chk(32'(c), 32'(r + 1));
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			{deep_sleep, dbg_halt} <= 2'b01 << k;
			repeat (2) @(posedge clk_sys);
			rd(stt_pkg::STT_ADDR_CURRENT, a0);
			repeat (3 * r) @(posedge clk_sys);
			rdchk(stt_pkg::STT_ADDR_CURRENT, a0);
			@(posedge clk_sys);
			{deep_sleep, dbg_halt} <= 2'b00;
		end
		wr(stt_pkg::STT_ADDR_CTRL, 32'h0000_0004);
		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0001_0004);
		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0000_0004);
		$display("test periodic_and_halt done");

		n0 = n_irq;
		start(32'(r), 32'h0000_0005);
		repeat (2 * r + 4) @(posedge clk_sys);
		chk(32'(n_irq), 32'(n0));
		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0001_0005);
		repeat (r + 2) @(posedge clk_sys);
		wr(stt_pkg::STT_ADDR_CTRL, 32'h0000_0004);
		wr(stt_pkg::STT_ADDR_CURRENT, $random(seed));
		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0000_0004);
		rdchk(stt_pkg::STT_ADDR_CURRENT, 32'h0000_0000);
		$display("test irq_masked_and_clear done");

		// Reload of zero: counter idles at zero and never flags
		n0 = n_irq;
		start(32'h0000_0000, 32'h0000_0007);
		repeat (40) @(posedge clk_sys);
		chk(32'(n_irq), 32'(n0));
		rdchk(stt_pkg::STT_ADDR_CTRL, 32'h0000_0007);
		$display("test zero_reload done");
		final_report();
	end
endmodule // tb_top
